// ===== src/ebp_port.sv
/*
 * External bus address and data port: drives the address pins with
 * address, DRAM row/column or interrupt level, muxes the top address byte
 * with gpio_pins, moves data on the bidirectional data bus and captures
 * reset straps from the low data byte.
 * Assumes the core issues one request at a time and holds it until
 * done_o; bus_clock_out is the clock itself, so rising edges are clock_i.
 */
`include "ebp_map.svh"

module ebp_port #(
    parameter int REGIONS = `EBP_REGIONS
) (
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   clk_en_i,
    input  wire logic                   req_i,
    input  wire logic                   write_i,
    input  wire ebp_pkg::ebp_kind_t     kind_i,
    input  wire ebp_pkg::ebp_size_t     size_i,
    input  wire logic [31:0]            addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic [31:0]            dram_col_i,
    input  wire logic [2:0]             iack_level_i,
    input  wire logic                   region_hit_i,
    input  wire logic [3:0]             region_idx_i,
    input  wire logic                   cfg_wr_i,
    input  wire logic [3:0]             cfg_idx_i,
    input  wire ebp_pkg::ebp_region_cfg_t cfg_data_i,
    input  wire logic                   ext_ack_i,
    input  wire logic                   bus_granted_i,
    input  wire logic [7:0]             pin_assign_reg_i,
    input  wire logic [7:0]             gpio_out_i,
    input  wire logic [7:0]             gpio_oe_i,
    input  wire logic [7:0]             upper_pin_i,
    input  wire logic [31:0]            data_pin_i,
    output logic [23:0]                 addr_lo_o,
    output logic                        addr_lo_oe_o,
    output logic [7:0]                  upper_pin_o,
    output logic [7:0]                  upper_pin_oe_o,
    output logic [7:0]                  gpio_in_o,
    output logic [31:0]                 data_pin_o,
    output logic                        data_pin_oe_o,
    output logic                        transfer_start_n_o,
    output logic                        addr_strobe_n_o,
    output logic [31:0]                 rdata_o,
    output logic                        done_o,
    output logic                        busy_o,
    output ebp_pkg::ebp_region_cfg_t    active_cfg_o,
    output logic                        auto_ack_strap_o,
    output logic [1:0]                  boot_width_strap_o,
    output logic                        upper_addr_strap_o,
    output logic [1:0]                  pll_multiplier_sel_o,
    output logic [1:0]                  clock_divide_sel_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CFG,
        ST_START,
        ST_WAIT,
        ST_COL
    } ebp_state_t;

    ebp_state_t               state_reg;
    ebp_state_t               state_next;
    logic [31:0]              addr_reg;
    logic [31:0]              wdata_reg;
    logic [31:0]              col_reg;
    logic [31:0]              rdata_reg;
    logic                     write_reg;
    logic                     hit_reg;
    ebp_pkg::ebp_kind_t       kind_reg;
    logic [`EBP_WAIT_W-1:0]   wait_reg;
    logic                     strap_done_reg;
    logic [7:0]               strap_reg;
    logic                     as_fall_reg;
    logic                     addr_phase;
    logic                     acked;
    logic [31:0]              bus_addr;
    ebp_pkg::ebp_region_cfg_t cur_cfg;
    ebp_pkg::ebp_region_cfg_t dflt_cfg;
    ebp_pkg::ebp_region_cfg_t boot_cfg;

    ebp_cfg_if cfg_bus ();

    // ------------------------------------------------------------------
    // Region table and strap-derived boot entry
    // ------------------------------------------------------------------
    // Entry 0 is loaded from the straps at release, then by software
    assign cfg_bus.wr_en  = cfg_wr_i || !strap_done_reg;
    assign cfg_bus.wr_idx = strap_done_reg ? cfg_idx_i : `EBP_BOOT_IDX;
    assign cfg_bus.wr_cfg = strap_done_reg ? cfg_data_i : boot_cfg;
    assign boot_cfg       = '{
        width:    data_pin_i[`EBP_STRAP_WIDTH_HI:`EBP_STRAP_WIDTH_LO],
        waits:    `EBP_BOOT_WAITS,
        auto_ack: data_pin_i[`EBP_STRAP_AUTO_ACK],
        burst_ok: 1'b0};
    assign cfg_bus.rd_idx = region_idx_i;

    ebp_cfg_table #(.REGIONS(REGIONS)) ebp_cfg_table_i (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .clk_en_i (clk_en_i),
        .cfg      (cfg_bus.table_side)
    );

    // Default for unmatched addresses: 32-bit, external ack, no burst
    assign dflt_cfg = '{width: `EBP_PORT_32, waits: 4'h0,
                        auto_ack: 1'b0, burst_ok: 1'b0};
    // Boot region (index 0) comes from straps until software rewrites it
    assign cur_cfg  = !hit_reg ? dflt_cfg : cfg_bus.rd_cfg;
    assign active_cfg_o = cur_cfg;

    // ------------------------------------------------------------------
    // Strap capture once after reset release
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_done_reg <= 1'b0;
            strap_reg      <= 8'h00;
        end else if (clk_en_i && !strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_reg      <= data_pin_i[7:0];
        end
    end

    assign auto_ack_strap_o     = strap_reg[`EBP_STRAP_AUTO_ACK];
    assign boot_width_strap_o   =
        strap_reg[`EBP_STRAP_WIDTH_HI:`EBP_STRAP_WIDTH_LO];
    assign upper_addr_strap_o   = strap_reg[`EBP_STRAP_UPPER_ADDR];
    assign pll_multiplier_sel_o =
        strap_reg[`EBP_STRAP_PLL_HI:`EBP_STRAP_PLL_LO];
    assign clock_divide_sel_o   =
        strap_reg[`EBP_STRAP_DIV_HI:`EBP_STRAP_DIV_LO];

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    assign acked = cur_cfg.auto_ack ? (wait_reg == '0) : ext_ack_i;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:  if (req_i && strap_done_reg && bus_granted_i)
                          state_next = ST_CFG;
            ST_CFG:   state_next = ST_START;
            ST_START: state_next = ST_WAIT;
            ST_WAIT:  if (acked)
                          state_next = (kind_reg == ebp_pkg::EBP_KIND_DRAM
                                        && addr_reg != col_reg)
                                       ? ST_COL : ST_IDLE;
            ST_COL:   state_next = ST_START;
        endcase
    end

    // Request capture, wait count and read sampling on rising edge
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            addr_reg  <= '0;
            wdata_reg <= '0;
            col_reg   <= '0;
            rdata_reg <= '0;
            write_reg <= 1'b0;
            hit_reg   <= 1'b0;
            kind_reg  <= ebp_pkg::EBP_KIND_NORMAL;
            wait_reg  <= '0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && state_next == ST_CFG) begin
                addr_reg  <= (kind_i == ebp_pkg::EBP_KIND_IACK)
                    ? {addr_i[31:5], iack_level_i, addr_i[1:0]}
                    : addr_i;
                col_reg   <= (kind_i == ebp_pkg::EBP_KIND_DRAM)
                    ? dram_col_i : addr_i;
                wdata_reg <= wdata_i;
                write_reg <= write_i;
                kind_reg  <= kind_i;
                hit_reg   <= region_hit_i;
            end
            if (state_reg == ST_START)
                wait_reg <= cur_cfg.waits;
            else if (state_reg == ST_WAIT && wait_reg != '0)
                wait_reg <= wait_reg - 1'b1;
            if (state_reg == ST_WAIT && acked && !write_reg)
                rdata_reg <= data_pin_i;
            if (state_reg == ST_COL)
                addr_reg <= col_reg;
        end
    end

    // addr_strobe moves on falling edges while the address phase stands
    assign addr_phase = (state_reg == ST_START) || (state_reg == ST_WAIT);

    always_ff @(negedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            as_fall_reg <= 1'b0;
        end else if (clk_en_i) begin
            as_fall_reg <= addr_phase;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    assign bus_addr           = addr_reg;
    assign transfer_start_n_o = !(state_reg == ST_START);
    assign addr_strobe_n_o    = !as_fall_reg;
    assign addr_lo_o          = bus_addr[23:0];
    assign addr_lo_oe_o       = bus_granted_i;

    // Each top pin picks address or gpio independently
    genvar g;
    generate
        for (g = 0; g < `EBP_UPPER_W; g++) begin : g_upper
            assign upper_pin_o[g]    = pin_assign_reg_i[g]
                ? bus_addr[24+g] : gpio_out_i[g];
            assign upper_pin_oe_o[g] = pin_assign_reg_i[g]
                ? bus_granted_i : gpio_oe_i[g];
            assign gpio_in_o[g]      = pin_assign_reg_i[g]
                ? 1'b0 : upper_pin_i[g];
        end
    endgenerate

    assign data_pin_o    = wdata_reg;
    assign data_pin_oe_o = write_reg && addr_phase;
    assign rdata_o       = rdata_reg;
    assign done_o        = (state_reg == ST_WAIT) && acked
                           && (state_next == ST_IDLE);
    assign busy_o        = (state_reg != ST_IDLE);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    ts_one_clock_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && !transfer_start_n_o) |=> transfer_start_n_o)
        else $error("transfer_start longer than one clock");

    ts_addr_valid_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        !transfer_start_n_o |-> addr_lo_oe_o ##1 $stable(addr_lo_o))
        else $error("lower address not valid at start");

    iack_level_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (!transfer_start_n_o && kind_reg == ebp_pkg::EBP_KIND_IACK)
        |-> addr_lo_o[4:2] == $past(iack_level_i, 2))
        else $error("interrupt level missing on address");

    pin_select_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        pin_assign_reg_i == 8'hFF |-> upper_pin_o == addr_reg[31:24])
        else $error("top address byte not on pins");

    write_drive_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (write_reg && state_reg == ST_WAIT) |-> data_pin_oe_o
        && data_pin_o == wdata_reg)
        else $error("write data not fully driven");

    strap_hold_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        $past(strap_done_reg) |-> $stable(strap_reg))
        else $error("strap values changed after capture");

    dflt_cfg_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (busy_o && !hit_reg) |-> active_cfg_o.width == `EBP_PORT_32
        && !active_cfg_o.auto_ack && !active_cfg_o.burst_ok)
        else $error("default region config wrong");

    read_sample_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && done_o && !write_reg) |=> rdata_o == $past(data_pin_i))
        else $error("read data not sampled");
endmodule

// ===== src/ebp_map.svh
/*
 * Constants for the external bus address/data port: strap bit positions,
 * widths, port size codes and the boot region index and wait count.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef EBP_MAP_SVH
`define EBP_MAP_SVH

// ----------------------------------------------------------------------
// Reset strap positions on the low data byte
// ----------------------------------------------------------------------
`define EBP_STRAP_AUTO_ACK     7
`define EBP_STRAP_WIDTH_HI     6
`define EBP_STRAP_WIDTH_LO     5
`define EBP_STRAP_UPPER_ADDR   4
`define EBP_STRAP_PLL_HI       3
`define EBP_STRAP_PLL_LO       2
`define EBP_STRAP_DIV_HI       1
`define EBP_STRAP_DIV_LO       0

// ----------------------------------------------------------------------
// Bus geometry and codes
// ----------------------------------------------------------------------
`define EBP_ADDR_W             32
`define EBP_DATA_W             32
`define EBP_UPPER_W            8
`define EBP_IACK_HI            4
`define EBP_IACK_LO            2
`define EBP_PORT_32            2'h0
`define EBP_PORT_8             2'h1
`define EBP_PORT_16            2'h2
`define EBP_REGIONS            10
`define EBP_WAIT_W             4
`define EBP_PAR_RESET          8'hFF
`define EBP_BOOT_IDX           4'h0
`define EBP_BOOT_WAITS         4'hF

`endif

// ===== src/ebp_pkg.sv
/*
 * Types shared by the external bus address/data port.
 * Assumes nothing of its surroundings.
 */
package ebp_pkg;
    typedef enum logic [1:0] {
        EBP_SZ_LONG,
        EBP_SZ_BYTE,
        EBP_SZ_WORD,
        EBP_SZ_LINE
    } ebp_size_t;

    typedef enum logic [1:0] {
        EBP_KIND_NORMAL,
        EBP_KIND_DRAM,
        EBP_KIND_IACK
    } ebp_kind_t;

    typedef struct packed {
        logic [1:0] width;
        logic [3:0] waits;
        logic       auto_ack;
        logic       burst_ok;
    } ebp_region_cfg_t;
endpackage

// ===== src/ebp_cfg_if.sv
/*
 * Carrier between the port top and its region configuration table.
 * Assumes a single clock shared by both modules.
 */
interface ebp_cfg_if;
    logic                     wr_en;
    logic [3:0]               wr_idx;
    ebp_pkg::ebp_region_cfg_t wr_cfg;
    logic [3:0]               rd_idx;
    ebp_pkg::ebp_region_cfg_t rd_cfg;

    modport table_side (
        input  wr_en, wr_idx, wr_cfg, rd_idx,
        output rd_cfg
    );
    modport user_side (
        output wr_en, wr_idx, wr_cfg, rd_idx,
        input  rd_cfg
    );
endinterface

// ===== src/ebp_cfg_table.sv
/*
 * Region configuration memory: width, wait states and termination for
 * every chip select region and DRAM bank; read data are registered.
 * Assumes writes and reads come from the port top on the same clock.
 */
`include "ebp_map.svh"

module ebp_cfg_table #(
    parameter int REGIONS = `EBP_REGIONS
) (
    input  wire logic     clock_i,
    input  wire logic     rst_n_i,
    input  wire logic     clk_en_i,
    ebp_cfg_if.table_side cfg
);
    ebp_pkg::ebp_region_cfg_t mem_reg [REGIONS];
    ebp_pkg::ebp_region_cfg_t rd_reg;

    // ------------------------------------------------------------------
    // Storage and registered read
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_reg <= '0;
        end else if (clk_en_i) begin
            rd_reg <= mem_reg[cfg.rd_idx];
        end
    end

    // Per-region entries written whole and independently
    always_ff @(posedge clock_i) begin
        if (clk_en_i && cfg.wr_en && cfg.wr_idx < REGIONS) begin
            mem_reg[cfg.wr_idx] <= cfg.wr_cfg;
        end
    end

    assign cfg.rd_cfg = rd_reg;
endmodule

// ===== test/ebp_mem_model.sv
/*
 * Far-side model of the external bus: a memory or peripheral that
 * presents reset straps on the low data byte and answers reads with an
 * acknowledge after a chosen delay.
 * Assumes the port's clock and active low reset; the bench resolves
 * the shared data wires from both drivers.
 */
module ebp_mem_model (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  strap_i,
    input  wire logic        ack_en_i,
    input  wire logic [3:0]  ack_delay_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        transfer_start_n_i,
    output logic [31:0]      data_pin_o,
    output logic             ext_ack_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       strap_hold_reg;
    logic       pending_reg;
    logic [3:0] delay_reg;

    // ---------------------------------------------------------------
    // Straps in reset, delayed answer, churning lines once released
    // ---------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_hold_reg <= 1'b1;
            pending_reg    <= 1'b0;
            delay_reg      <= 4'h0;
            ext_ack_o      <= 1'b0;
            data_pin_o     <= {24'h000000, strap_i};
        end else begin
            strap_hold_reg <= 1'b0;
            ext_ack_o      <= 1'b0;
            if (!strap_hold_reg) begin
                data_pin_o <= ~data_pin_o; // Released: no stale value
            end
            if (pending_reg && delay_reg == 4'h0) begin
                pending_reg <= 1'b0;
                ext_ack_o   <= 1'b1;
                data_pin_o  <= rdata_i;
            end else if (pending_reg) begin
                delay_reg <= delay_reg - 4'h1;
            end else if (!transfer_start_n_i && ack_en_i) begin
                pending_reg <= 1'b1;
                delay_reg   <= ack_delay_i;
            end
        end
    end
endmodule

// ===== test/ext_bus_addr_data_port_test.sv
/*
 * Self-checking bench for the external bus address/data port.
 * Assumes the port and the memory model compiled before it.
 */
`include "ebp_map.svh"

module ext_bus_addr_data_port_test;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] STRAPS = 8'hB6;

    logic clock_i, rst_n_i, clk_en, req, wr, hit, cfg_wr, granted, ack_en;
    logic done, busy, ts_n, as_n, d_oe, alo_oe, ext_ack;
    logic s_aa, s_up;
    logic [1:0]  s_w, s_pll, s_div;
    logic [2:0]  lvl;
    logic [3:0]  ridx, cfg_idx, ack_dly;
    logic [7:0]  pa, gp_out, gp_oe, up_ext, up_o, up_oe, gp_in, up_pin;
    logic [23:0] addr_lo, ts_a0, ts_a1;
    logic [31:0] addr, wdata, col, d_o, d_pin, mem_d, mem_rd, rdata;
    logic [7:0]  ts_up, ts_upoe;
    logic [31:0] ts_dout;
    logic        ts_doe;
    ebp_pkg::ebp_kind_t       kind;
    ebp_pkg::ebp_size_t       size;
    ebp_pkg::ebp_region_cfg_t cfg_data, act_cfg, ts_cfg;
    int fail_count, num_checks, ts_cnt, cyc;

    // Shared wires resolved from both drivers
    assign d_pin  = d_oe ? d_o : mem_d;
    assign up_pin = (up_oe & up_o) | (~up_oe & up_ext);

    ebp_port ebp_port_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
        .req_i(req), .write_i(wr), .kind_i(kind), .size_i(size),
        .addr_i(addr), .wdata_i(wdata), .dram_col_i(col),
        .iack_level_i(lvl), .region_hit_i(hit), .region_idx_i(ridx),
        .cfg_wr_i(cfg_wr), .cfg_idx_i(cfg_idx), .cfg_data_i(cfg_data),
        .ext_ack_i(ext_ack), .bus_granted_i(granted),
        .pin_assign_reg_i(pa), .gpio_out_i(gp_out), .gpio_oe_i(gp_oe),
        .upper_pin_i(up_pin), .data_pin_i(d_pin), .addr_lo_o(addr_lo),
        .addr_lo_oe_o(alo_oe), .upper_pin_o(up_o), .upper_pin_oe_o(up_oe),
        .gpio_in_o(gp_in), .data_pin_o(d_o), .data_pin_oe_o(d_oe),
        .transfer_start_n_o(ts_n), .addr_strobe_n_o(as_n),
        .rdata_o(rdata), .done_o(done), .busy_o(busy),
        .active_cfg_o(act_cfg), .auto_ack_strap_o(s_aa),
        .boot_width_strap_o(s_w), .upper_addr_strap_o(s_up),
        .pll_multiplier_sel_o(s_pll), .clock_divide_sel_o(s_div));

    ebp_mem_model ebp_mem_model_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .strap_i(STRAPS),
        .ack_en_i(ack_en), .ack_delay_i(ack_dly), .rdata_i(mem_rd),
        .transfer_start_n_i(ts_n), .data_pin_o(mem_d),
        .ext_ack_o(ext_ack));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One core request, held until done; records the start cycles
    task automatic xfer(input logic w, input ebp_pkg::ebp_kind_t k,
                        input logic [31:0] a);
        int   guard;
        logic prev;
        @(posedge clock_i);
        #1;
        wr = w; kind = k; addr = a; req = 1'b1;
        guard = 0; prev = 1'b0; ts_cnt = 0; cyc = 0;
        do begin
            @(posedge clock_i);
            #1;
            guard++;
            if (prev) begin
                chk(32'(ts_n), 32'h1);
                chk(32'(as_n), 32'h0);
            end
            prev = (ts_n === 1'b0);
            if (prev && ts_cnt == 1) ts_a1 = addr_lo;
            if (prev && ts_cnt == 0) begin
                ts_a0 = addr_lo; ts_up = up_o; ts_upoe = up_oe;
                ts_doe = d_oe; ts_dout = d_o; ts_cfg = act_cfg;
            end
            if (prev) ts_cnt++;
            if (ts_cnt > 0) cyc++;
        end while (done !== 1'b1 && guard < 40);
        chk(32'(done), 32'h1);
        @(posedge clock_i);
        #1;
        req = 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_straps();
        chk(32'(s_aa), 32'(STRAPS[7]));
        chk(32'(s_w), 32'(STRAPS[6:5]));
        chk(32'(s_up), 32'(STRAPS[4]));
        chk(32'(s_pll), 32'(STRAPS[3:2]));
        chk(32'(s_div), 32'(STRAPS[1:0]));
    endtask

    task automatic t_read();
        pa = 8'hFF; hit = 1'b0; ack_en = 1'b1; ack_dly = 4'h2;
        mem_rd = 32'h5A0FC3E1;
        xfer(1'b0, ebp_pkg::EBP_KIND_NORMAL, 32'h9ABCDEF1);
        chk(32'(ts_a0), 32'h00BCDEF1);
        chk(32'(ts_up), 32'h9A);
        chk(32'(ts_cfg), 32'h0);
        chk(32'(cyc), 32'h5);
        chk(rdata, mem_rd);
    endtask

    task automatic t_region();
        logic [7:0] boot;
        boot = {STRAPS[6:5], `EBP_BOOT_WAITS, STRAPS[7], 1'b0};
        hit = 1'b1;
        ridx = 4'h0;
        ack_en = 1'b0;
        xfer(1'b0, ebp_pkg::EBP_KIND_NORMAL, 32'h00000800);
        chk(32'(ts_cfg), 32'(boot));
        chk(32'(cyc), 32'(`EBP_BOOT_WAITS) + 32'h2);
        @(posedge clock_i);
        #1;
        cfg_wr = 1'b1; cfg_idx = 4'h3; cfg_data = 8'h4E;
        @(posedge clock_i);
        #1;
        cfg_wr = 1'b0; hit = 1'b1; ridx = 4'h3; ack_en = 1'b0;
        xfer(1'b0, ebp_pkg::EBP_KIND_NORMAL, 32'h00001000);
        chk(32'(ts_cfg), 32'h4E);
        chk(32'(cyc), 32'h5);
    endtask

    task automatic t_write();
        ebp_pkg::ebp_size_t szs[3];
        szs = '{ebp_pkg::EBP_SZ_LONG, ebp_pkg::EBP_SZ_BYTE,
                ebp_pkg::EBP_SZ_WORD};
        for (int i = 0; i < 3; i++) begin
            size = szs[i]; wdata = 32'hA5C30F96 ^ 32'(i);
            xfer(1'b1, ebp_pkg::EBP_KIND_NORMAL, 32'h00002001);
            chk(32'(ts_doe), 32'h1);
            chk(ts_dout, wdata);
        end
    endtask

    task automatic t_dram();
        col = 32'h00123456;
        xfer(1'b0, ebp_pkg::EBP_KIND_DRAM, 32'h00654320);
        chk(32'(ts_cnt), 32'h2);
        chk(32'(ts_a0), 32'h00654320);
        chk(32'(ts_a1), col & 32'h00FFFFFF);
    endtask

    task automatic t_iack();
        hit = 1'b0; ack_en = 1'b1; ack_dly = 4'h0;
        for (int i = 1; i < 8; i++) begin
            lvl = 3'(i);
            xfer(1'b0, ebp_pkg::EBP_KIND_IACK, 32'h00FFFFE3);
            chk(32'(ts_a0), {8'h00, 19'h7FFFF, 3'(i), 2'h3});
        end
    endtask

    task automatic t_gpio();
        pa = 8'hA5; gp_out = 8'h3C; gp_oe = 8'h0F; up_ext = 8'h96;
        #1;
        chk(32'(up_o & ~pa), 32'(gp_out & ~pa));
        chk(32'(up_oe & ~pa), 32'(gp_oe & ~pa));
        chk(32'(gp_in),
            32'(((gp_oe & gp_out) | (~gp_oe & up_ext)) & ~pa));
        xfer(1'b0, ebp_pkg::EBP_KIND_NORMAL, 32'hC3000010);
        chk(32'(ts_up & pa), 32'(8'hC3 & pa));
        chk(32'(ts_upoe & pa), 32'(pa));
    endtask

    // Bus owned elsewhere: address pins released, requests refused
    task automatic t_extmaster();
        @(posedge clock_i);
        #1;
        granted = 1'b0;
        wr = 1'b0;
        addr = 32'h12345678;
        req = 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        chk(32'(alo_oe), 32'h0);
        chk(32'(up_oe & pa), 32'h0);
        chk(32'(busy), 32'h0);
        chk(32'(ts_n), 32'h1);
        req = 1'b0;
        @(posedge clock_i);
        #1;
        granted = 1'b1;
    endtask

    // ---------------------------------------------------------------
    // Clock, main sequence and watchdog
    // ---------------------------------------------------------------
    always #2 clock_i = ~clock_i;

    initial begin
        clock_i = 1'b0; rst_n_i = 1'b0; clk_en = 1'b1; granted = 1'b1;
        req = 1'b0; wr = 1'b0; hit = 1'b0; cfg_wr = 1'b0; ack_en = 1'b1;
        kind = ebp_pkg::EBP_KIND_NORMAL; size = ebp_pkg::EBP_SZ_LONG;
        addr = 32'h0; wdata = 32'h0; col = 32'h0; lvl = 3'h0;
        ridx = 4'h0; cfg_idx = 4'h0; cfg_data = 8'h00; ack_dly = 4'h0;
        pa = 8'hFF; gp_out = 8'h00; gp_oe = 8'h00; up_ext = 8'h00;
        mem_rd = 32'h0; fail_count = 0; num_checks = 0;
        repeat (6) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        t_straps();
        t_read();
        t_region();
        t_write();
        t_dram();
        t_iack();
        t_gpio();
        t_extmaster();
        t_straps();
        conclude();
    end

    initial begin
        #8000;
        fail_count++;
        conclude();
    end
endmodule
